/* rtl/qdd_pkg.sv */
package qdd_pkg;
   localparam logic [7:0] ADDR_CSR   = 8'h90;
   localparam logic [7:0] ADDR_CFG   = 8'h91;
   localparam logic [7:0] ADDR_CNT1  = 8'h94;
   localparam logic [7:0] ADDR_CNT2  = 8'h96;
   localparam int         CNT_W      = 8;
   localparam logic [7:0] CNT_MAX    = 8'hff;
   localparam logic [7:0] CNT_ZERO   = 8'h00;
   // status register fields
   localparam int CSR_CH2_UP    = 7;
   localparam int CSR_CH2_DN    = 6;
   localparam int CSR_CH2_CLR   = 4;
   localparam int CSR_CH1_UP    = 3;
   localparam int CSR_CH1_DN    = 2;
   localparam int CSR_CH1_CLR   = 0;
   // config register fields
   localparam int CFG_SEL2_HI   = 7;
   localparam int CFG_SEL2_LO   = 6;
   localparam int CFG_SEL1_HI   = 3;
   localparam int CFG_SEL1_LO   = 2;
   localparam int CFG_PRI_HI    = 1;
   localparam int CFG_PRI_LO    = 0;
   localparam logic [1:0] SEL_OFF  = 2'h0;
   localparam logic [1:0] SEL_LOW  = 2'h2;
   localparam logic [1:0] SEL_HIGH = 2'h3;
   localparam logic [1:0] PRI_OFF  = 2'h0;
   // port bit pairs per channel and selection (in-phase bit is the odd one)
   localparam int CH1_LOW_I  = 1;
   localparam int CH1_HIGH_I = 5;
   localparam int CH2_LOW_I  = 3;
   localparam int CH2_HIGH_I = 7;
   // a filtered level changes after this many equal ticks
   localparam logic [1:0] FILT_TICKS = 2'h2;

   typedef struct packed {
      logic       i;
      logic       q;
   } qdd_phase_s;

   typedef struct packed {
      logic       up;
      logic       dn;
   } qdd_wrap_s;
endpackage : qdd_pkg

/* rtl/qdd_channel.sv */
`timescale 1ns/100ps
module qdd_channel #(
   parameter int CNT_W = qdd_pkg::CNT_W
) (
   input  wire logic               clk,
   input  wire logic               reset,
   input  wire logic               tick,
   input  wire logic               enable,
   input  wire qdd_pkg::qdd_phase_s raw,
   input  wire logic               clear,
   output qdd_pkg::qdd_wrap_s      wrap,
   output logic [CNT_W-1:0]        count
);
   typedef struct packed {
      logic [1:0]       ci;
      logic [1:0]       cq;
      logic             fi;
      logic             fq;
      logic             valid;
      logic [CNT_W-1:0] cnt;
      logic             up;
      logic             dn;
   } qdd_ch_s;

   qdd_ch_s st_q;
   qdd_ch_s st_d;

   always_comb begin
      st_d    = st_q;
      st_d.up = 1'b0;
      st_d.dn = 1'b0;
      if (!enable) begin
         // filters reload on re-enable, so no phantom step on entry or exit
         st_d.valid = 1'b0;
         st_d.ci    = '0;
         st_d.cq    = '0;
      end else if (tick) begin
         // level must hold two ticks before the filtered copy follows
         if (raw.i == st_q.fi || !st_q.valid) st_d.ci = '0;
         else if (st_q.ci != qdd_pkg::FILT_TICKS - 2'h1) st_d.ci = st_q.ci + 2'h1;
         else begin
            st_d.ci = '0;
            st_d.fi = raw.i;
         end
         if (raw.q == st_q.fq || !st_q.valid) st_d.cq = '0;
         else if (st_q.cq != qdd_pkg::FILT_TICKS - 2'h1) st_d.cq = st_q.cq + 2'h1;
         else begin
            st_d.cq = '0;
            st_d.fq = raw.q;
         end
         if (!st_q.valid) begin
            st_d.fi    = raw.i;
            st_d.fq    = raw.q;
            st_d.valid = 1'b1;
         end else if ((st_d.fi != st_q.fi) ^ (st_d.fq != st_q.fq)) begin
            // i leading: after the step i and q differ when i moved
            if ((st_d.fi ^ st_d.fq) == (st_d.fi != st_q.fi)) begin
               st_d.cnt = st_q.cnt + 1'b1;
               st_d.up  = (st_q.cnt == qdd_pkg::CNT_MAX);
            end else begin
               st_d.cnt = st_q.cnt - 1'b1;
               st_d.dn  = (st_q.cnt == qdd_pkg::CNT_ZERO);
            end
         end
      end
      if (clear) begin
         st_d.cnt = qdd_pkg::CNT_ZERO;
         st_d.up  = 1'b0;
         st_d.dn  = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) st_q <= '0;
      else st_q <= st_d;
   end

   assign wrap.up = st_q.up;
   assign wrap.dn = st_q.dn;
   assign count   = st_q.cnt;
endmodule : qdd_channel

/* rtl/qdd_top.sv */
`timescale 1ns/100ps
module qdd_top #(
   parameter int CNT_W = qdd_pkg::CNT_W
) (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       sample_tick,
   input  wire logic [7:0] port_in,
   input  wire logic [7:0] io_addr,
   input  wire logic       io_wr,
   input  wire logic       io_rd,
   input  wire logic [7:0] io_wdata,
   output logic      [7:0] io_rdata,
   output logic            irq,
   output logic      [1:0] irq_priority
);
   typedef struct packed {
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [1:0] sel1;
      logic [1:0] sel2;
      logic [1:0] pri;
      logic [3:0] flags;
      logic [7:0] rdata;
   } qdd_top_s;

   qdd_top_s st_q;
   qdd_top_s st_d;

   qdd_pkg::qdd_wrap_s  wrap [2];
   qdd_pkg::qdd_phase_s raw  [2];
   logic [CNT_W-1:0]    cnt  [2];
   logic [1:0]          sel  [2];
   logic [1:0]          clr;
   logic                csr_rd;
   logic                cfg_wr;
   logic                csr_wr;
   logic [1:0]          pri_w;
   logic [1:0]          flag_up;
   logic [1:0]          flag_dn;

   assign csr_rd = io_rd && (io_addr == qdd_pkg::ADDR_CSR);
   assign csr_wr = io_wr && (io_addr == qdd_pkg::ADDR_CSR);
   assign cfg_wr = io_wr && (io_addr == qdd_pkg::ADDR_CFG);
   assign clr[0] = csr_wr && io_wdata[qdd_pkg::CSR_CH1_CLR];
   assign clr[1] = csr_wr && io_wdata[qdd_pkg::CSR_CH2_CLR];
   assign sel[0] = st_q.sel1;
   assign sel[1] = st_q.sel2;

   // pin pairs by channel: low and high odd in-phase bit
   localparam int LOW_I  [2] = '{qdd_pkg::CH1_LOW_I,  qdd_pkg::CH2_LOW_I};
   localparam int HIGH_I [2] = '{qdd_pkg::CH1_HIGH_I, qdd_pkg::CH2_HIGH_I};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         always_comb begin
            raw[g] = '0;
            case (sel[g])
               qdd_pkg::SEL_LOW: begin
                  raw[g].i = st_q.sync2[LOW_I[g]];
                  raw[g].q = st_q.sync2[LOW_I[g]-1];
               end
               qdd_pkg::SEL_HIGH: begin
                  raw[g].i = st_q.sync2[HIGH_I[g]];
                  raw[g].q = st_q.sync2[HIGH_I[g]-1];
               end
               default: raw[g] = '0;
            endcase
         end

         qdd_channel #(
            .CNT_W (CNT_W)
         ) u_ch (
            .clk    (clk),
            .reset  (reset),
            .tick   (sample_tick),
            .enable (sel[g][1]),
            .raw    (raw[g]),
            .clear  (clr[g]),
            .wrap   (wrap[g]),
            .count  (cnt[g])
         );
         assign flag_up[g] = wrap[g].up;
         assign flag_dn[g] = wrap[g].dn;
      end
   endgenerate

   assign pri_w = io_wdata[qdd_pkg::CFG_PRI_HI:qdd_pkg::CFG_PRI_LO];

   always_comb begin
      st_d       = st_q;
      st_d.sync1 = port_in;
      st_d.sync2 = st_q.sync1;
      if (cfg_wr) begin
         // bits 5:4 are simply never stored
         st_d.sel2 = io_wdata[qdd_pkg::CFG_SEL2_HI:qdd_pkg::CFG_SEL2_LO];
         st_d.sel1 = io_wdata[qdd_pkg::CFG_SEL1_HI:qdd_pkg::CFG_SEL1_LO];
         st_d.pri  = pri_w;
      end
      if (csr_rd) st_d.flags = '0;
      // set wins over the read-clear so a wrap at the read is kept
      st_d.flags = st_d.flags | {flag_up[1], flag_dn[1], flag_up[0], flag_dn[0]};
      st_d.rdata = '0;
      if (io_rd) begin
         case (io_addr)
            qdd_pkg::ADDR_CSR: begin
               st_d.rdata[qdd_pkg::CSR_CH2_UP] = st_q.flags[3];
               st_d.rdata[qdd_pkg::CSR_CH2_DN] = st_q.flags[2];
               st_d.rdata[qdd_pkg::CSR_CH1_UP] = st_q.flags[1];
               st_d.rdata[qdd_pkg::CSR_CH1_DN] = st_q.flags[0];
            end
            qdd_pkg::ADDR_CNT1: st_d.rdata = cnt[0];
            qdd_pkg::ADDR_CNT2: st_d.rdata = cnt[1];
            default: st_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) st_q <= '0;
      else st_q <= st_d;
   end

   assign io_rdata     = st_q.rdata;
   assign irq          = (st_q.flags != 4'h0) && (st_q.pri != qdd_pkg::PRI_OFF);
   assign irq_priority = st_q.pri;

   chk_flag_on_wrap: assert property (@(posedge clk) disable iff (reset)
      (flag_up[0] || flag_dn[0]) |=> st_q.flags[1:0] != 2'h0)
      else $error("wrap did not set status flag");
   chk_read_clears: assert property (@(posedge clk) disable iff (reset)
      (csr_rd && flag_up == 2'h0 && flag_dn == 2'h0) |=> st_q.flags == 4'h0)
      else $error("status read did not clear flags");
   chk_irq_flag: assert property (@(posedge clk) disable iff (reset)
      irq |-> st_q.flags != 4'h0)
      else $error("interrupt without flag");
   chk_reserved_zero: assert property (@(posedge clk) disable iff (reset)
      $past(csr_rd) |-> io_rdata[5] == 1'b0 && io_rdata[1] == 1'b0)
      else $error("reserved status bit nonzero");
   chk_clear_count: assert property (@(posedge clk) disable iff (reset)
      clr[0] |=> cnt[0] == qdd_pkg::CNT_ZERO && !flag_up[0] && !flag_dn[0])
      else $error("counter clear failed");
   chk_count_read: assert property (@(posedge clk) disable iff (reset)
      (io_rd && io_addr == qdd_pkg::ADDR_CNT2) |=> io_rdata == $past(cnt[1]))
      else $error("count read mismatch");
   chk_pri_off: assert property (@(posedge clk) disable iff (reset)
      st_q.pri == qdd_pkg::PRI_OFF |-> !irq)
      else $error("interrupt while disabled");
   chk_idle_no_step: assert property (@(posedge clk) disable iff (reset)
      !sample_tick && !clr[1] |=> $stable(cnt[1]))
      else $error("count moved without tick");
endmodule : qdd_top

/* tb/qdd_enc_model.sv */
`timescale 1ns/100ps
module qdd_enc_model (
   output logic [7:0] pins
);
   logic [1:0] pos_q [4] = '{default: 2'h0};
   logic [7:0] glitch    = 8'h00;
   // gray steps move one phase at a time, so edges never share a tick
   task automatic step(input int p, input logic up);
      pos_q[p] = up ? pos_q[p] + 2'h1 : pos_q[p] - 2'h1;
   endtask : step
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         pins[2*p+1] = pos_q[p][1] ^ pos_q[p][0] ^ glitch[2*p+1];
         pins[2*p]   = pos_q[p][1] ^ glitch[2*p];
      end
   end
endmodule : qdd_enc_model

/* tb/dual_quadrature_decoder_test.sv */
`timescale 1ns/100ps
module dual_quadrature_decoder_test;
   logic        clk = 1'b0, reset = 1'b1, sample_tick = 1'b0, io_wr = 1'b0, io_rd = 1'b0, irq;
   logic [7:0]  port_in, io_rdata, rd_v, flags, io_addr = 8'h00, io_wdata = 8'h00;
   logic [7:0]  cnt_q [3];
   logic [7:0]  addrs [5] = '{8'h90, 8'h91, 8'h92, 8'h94, 8'h96};
   logic [1:0]  irq_priority, prio;
   logic [31:0] seed = 32'h6f35;
   int          fail_count = 0, samples_checked = 0, tick_n = 0;

   qdd_top #(.CNT_W(8)) dut (.clk(clk), .reset(reset), .sample_tick(sample_tick),
      .port_in(port_in), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
      .io_wdata(io_wdata), .io_rdata(io_rdata), .irq(irq), .irq_priority(irq_priority));
   qdd_enc_model enc (.pins(port_in));

   initial begin
      forever #5 clk = ~clk;
   end
   // one tick in four cycles keeps well under half the clock rate
   always @(negedge clk) begin
      tick_n <= (tick_n + 1) % 4;
      sample_tick <= (tick_n == 3);
   end

   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   function automatic logic [7:0] wrap_bits(input logic [7:0] c, input logic up, input int ch);
      if (up && c == 8'hff) return (ch == 1) ? 8'h08 : 8'h80;
      if (!up && c == 8'h00) return (ch == 1) ? 8'h04 : 8'h40;
      return 8'h00;
   endfunction : wrap_bits

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check_byte
   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask : check_bit
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      io_addr = a;
      io_wdata = d;
      io_wr = 1'b1;
      @(negedge clk);
      io_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(negedge clk);
      io_addr = a;
      io_rd = 1'b1;
      @(negedge clk);
      io_rd = 1'b0;
      rd_v = io_rdata;
   endtask : rd
   task automatic wcfg(input logic [7:0] d);
      wr(8'h91, d);
      prio = d[1:0];
      repeat (24) @(negedge clk);
   endtask : wcfg
   task automatic chk_cnt(input int ch);
      rd((ch == 1) ? 8'h94 : 8'h96);
      check_byte(rd_v, cnt_q[ch]);
   endtask : chk_cnt
   task automatic csr_chk();
      rd(8'h90);
      check_byte(rd_v, flags);
      flags = 8'h00;
   endtask : csr_chk
   task automatic move(input int ch, input int p, input logic up);
      enc.step(p, up);
      repeat (24) @(negedge clk);
      if (ch != 0) begin
         flags |= wrap_bits(cnt_q[ch], up, ch);
         cnt_q[ch] = up ? cnt_q[ch] + 8'h01 : cnt_q[ch] - 8'h01;
         chk_cnt(ch);
      end
      check_bit(irq, (flags != 8'h00) && (prio != 2'h0));
   endtask : move
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      cnt_q = '{default: 8'h00};
      flags = 8'h00;
      prio = 2'h0;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      foreach (addrs[k]) begin
         rd(addrs[k]);
         check_byte(rd_v, 8'h00);
      end
      check_byte({6'h00, irq_priority}, 8'h00);
      $display("test reset done");
      // bits 5:4 set on purpose: they must be ignored
      wcfg(8'hb9);
      check_byte({6'h00, irq_priority}, 8'h01);
      move(1, 0, 1'b0);
      csr_chk();
      check_bit(irq, 1'b0);
      csr_chk();
      $display("test wrap done");
      for (int n = 0; n < 60; n++) begin
         seed = xs(seed);
         move(1 + seed[0], seed[0], seed[1]);
         if (seed[4:2] == 3'h0) csr_chk();
      end
      csr_chk();
      $display("test random done");
      enc.glitch = 8'h02;
      repeat (4) @(negedge clk);
      enc.glitch = 8'h00;
      repeat (24) @(negedge clk);
      chk_cnt(1);
      wr(8'h90, 8'h00);
      chk_cnt(1);
      wr(8'h90, 8'h11);
      cnt_q = '{default: 8'h00};
      chk_cnt(1);
      chk_cnt(2);
      csr_chk();
      $display("test clear done");
      wcfg(8'h01);
      move(0, 0, 1'b1);
      move(0, 3, 1'b1);
      wcfg(8'hfc);
      chk_cnt(1);
      chk_cnt(2);
      move(1, 2, 1'b0);
      move(2, 3, 1'b1);
      csr_chk();
      $display("test select done");
      for (int p = 1; p < 4; p++) begin
         wcfg(8'hfc | 8'(p));
         check_byte({6'h00, irq_priority}, 8'(p));
      end
      $display("test priority done");
      finish_test();
   end
   initial begin
      #200000;
      fail_count++;
      finish_test();
   end
endmodule : dual_quadrature_decoder_test
